// ===== hw/mmd_defs.svh
/*
 * Named constants of the memory map decoder: address limits, register
 * offsets, field positions and reset values.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// Program memory limits.
`define MMD_FLASH_TOP    16'h3dff
`define MMD_FLASH_BASE   16'h0000

// Internal RAM and on-chip XRAM geometry.
`define MMD_IRAM_AW      8
`define MMD_XRAM_AW      9
`define MMD_DIR_SFR_BIT  7
`define MMD_BIT_BASE     8'h20

// Bank select field inside the status word.
`define MMD_BANK_HI      4
`define MMD_BANK_LO      3

// Own special function register offsets.
`define MMD_SFR_SP       8'h81
`define MMD_SFR_PAGE     8'haa

// Reset values and small constants.
`define MMD_SP_RESET     8'h07
`define MMD_PAGE_RESET   8'h00
`define MMD_BYTE_ZERO    8'h00
`define MMD_HIGH_ZERO    7'h00
`define MMD_INC          8'h01

`endif

// ===== hw/mmd_pkg.sv
/*
 * Types shared by the memory map decoder files: operation codes,
 * access targets and the packed carriers of request, answer and ports.
 * Assumes the constant header is on the include path.
 */
`include "mmd_defs.svh"

package mmd_pkg;

    // Kind of access the core asks for.
    typedef enum logic [3:0] {
        OP_CODE_RD, OP_XDATA_RD, OP_XDATA_WR, OP_DIR_RD, OP_DIR_WR,
        OP_IND_RD, OP_IND_WR, OP_BIT_RD, OP_BIT_WR, OP_PUSH, OP_POP
    } mmd_op_type;

    // Where a decoded access lands.
    typedef enum logic [2:0] {
        T_NONE, T_FLASH, T_IRAM, T_XRAM, T_SFR, T_SP, T_PAGE
    } mmd_tgt_type;

    // Request from the instruction execution unit.
    typedef struct packed {
        mmd_op_type  op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wbit;
        logic        ptr_sel;
        logic        via_ri;
    } mmd_req_type;

    // Answer to the instruction execution unit.
    typedef struct packed {
        logic [7:0] data;
        logic       bitval;
        logic       reserved;
        logic       lock_byte;
    } mmd_rsp_type;

    // Strobe port towards flash or the outer register space.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mmd_ext_type;

endpackage

// ===== hw/mmd_ram.sv
/*
 * Single port byte memory with registered read data.
 * Assumes write enable and address are stable around the rising clock.
 */
`timescale 1ns/100ps
`include "mmd_defs.svh"

module mmd_ram #(
    parameter int AW = `MMD_IRAM_AW
) (
    // Clock and freeze.
    input  wire logic          mclk,
    input  wire logic          ce,
    // Access.
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata_ff
);
    logic [7:0] mem [0:(1<<AW)-1];

    // Contents carry no reset, so the array maps onto plain RAM cells.
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata_ff <= mem[addr];
        end
    end
endmodule

// ===== hw/mmd_bitsel.sv
/*
 * Maps a bit address onto its byte address and bit position.
 * Assumes a purely combinational use inside the decoder.
 */
`timescale 1ns/100ps
`include "mmd_defs.svh"

module mmd_bitsel (
    // Bit address from the instruction.
    input  wire logic [7:0] bit_addr,
    // Decoded location.
    output logic      [7:0] byte_addr,
    output logic      [2:0] bit_pos,
    output logic            to_sfr
);
    // Low half sits in bytes from the bit area base; high half in the
    // registers whose offsets end in zero or eight.
    assign to_sfr    = bit_addr[`MMD_DIR_SFR_BIT];
    assign bit_pos   = bit_addr[2:0];
    assign byte_addr = to_sfr ? {bit_addr[7:3], 3'h0}
                     : `MMD_BIT_BASE + {4'h0, bit_addr[6:3]};
endmodule

// ===== hw/mmd_decoder.sv
/*
 * Memory map decoder: routes core accesses to flash, internal RAM,
 * on-chip XRAM or the register space, and holds stack pointer and page.
 * Assumes flash and outer register space answer one cycle after a strobe.
 */
// What this block does
// - Flash program memory is one block from 0x0000 up to 0x3dff.
// - Byte 0x3dff is the lock byte; higher program addresses are reserved.
// - Code reads use flash; external writes reach flash only when enabled.
// - Otherwise external moves read and write the on-chip XRAM.
// - Internal RAM spans 0x00-0xff; low half by direct or indirect access.
// - Above 0x7f direct goes to registers, indirect to upper RAM.
// - Bytes 0x00-0x1f form four banks; status bits 4:3 pick one.
// - Indirect pointers come from register 0 or 1 of active bank.
// - Bytes 0x20-0x2f also form 128 bits: eight times offset plus bit.
// - Bit or byte access chosen by operation kind.
// - Stack pointer holds last used byte; push writes pointer plus one.
// - Reset loads the stack pointer with 0x07.
// - The stack may live anywhere in the 256 internal bytes.
// - A 512-byte XRAM fills the external space, by pointer or register.
// - 8-bit external moves take the high byte from the page register.
// - Top seven bits of 16-bit external addresses are ignored.
// - Page register bits 7:1 read zero, ignore writes, reset zero.
// - Page bit 0 set to one selects XRAM bytes 0x0100 to 0x01ff.
// - Bank field 00..11 maps to 0x00, 0x08, 0x10, 0x18 bases.
`timescale 1ns/100ps
`include "mmd_defs.svh"

module mmd_decoder
    import mmd_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Request from the execution unit.
    input  wire logic        req_valid,
    input  wire mmd_req_type req,
    output logic             req_ready,
    // Answer to the execution unit.
    output logic             rsp_valid,
    output mmd_rsp_type      rsp,
    // Core state and flash write mode.
    input  wire logic [7:0]  program_status_word,
    input  wire logic        flash_wr_enable,
    // Flash port.
    output mmd_ext_type      flash_port,
    input  wire logic [7:0]  flash_rdata,
    // Outer register space port.
    output mmd_ext_type      sfr_port,
    input  wire logic [7:0]  sfr_rdata,
    // Own registers seen from outside.
    output logic      [7:0]  stack_pointer,
    output logic      [7:0]  xram_page_register
);
    typedef enum logic [2:0] {S_IDLE, S_PTR, S_ACC, S_DONE, S_WB} mmd_st_type;

    mmd_st_type  state_ff,   nxt_state;
    mmd_req_type req_ff,     nxt_req;
    mmd_tgt_type tgt_ff,     nxt_tgt;
    mmd_rsp_type rsp_ff,     nxt_rsp;
    mmd_ext_type flash_ff,   nxt_flash;
    mmd_ext_type sfr_ff,     nxt_sfr;
    logic [15:0] addr_ff,    nxt_addr;
    logic [2:0]  bitpos_ff,  nxt_bitpos;
    logic [7:0]  sp_ff,      nxt_sp;
    logic [7:0]  page_ff,    nxt_page;
    logic        ready_ff,   nxt_ready;
    logic        rspv_ff,    nxt_rspv;

    logic        iram_we,    xram_we;
    logic [7:0]  iram_addr,  iram_wdata, iram_rdata;
    logic [8:0]  xram_addr;
    logic [7:0]  xram_wdata, xram_rdata;
    logic [7:0]  bs_byte;
    logic [2:0]  bs_pos;
    logic        bs_sfr;
    logic [1:0]  bank;
    logic        accept;

    // Active bank straight from the status word field.
    assign bank   = program_status_word[`MMD_BANK_HI:`MMD_BANK_LO];
    assign accept = ready_ff && req_valid;

    // One array covers all 256 bytes, upper half being indirect only.
    mmd_ram #(.AW(`MMD_IRAM_AW)) u_iram (
        .mclk     (mclk),
        .ce       (ce),
        .we       (iram_we),
        .addr     (iram_addr),
        .wdata    (iram_wdata),
        .rdata_ff (iram_rdata)
    );
    mmd_ram #(.AW(`MMD_XRAM_AW)) u_xram (
        .mclk     (mclk),
        .ce       (ce),
        .we       (xram_we),
        .addr     (xram_addr),
        .wdata    (xram_wdata),
        .rdata_ff (xram_rdata)
    );
    mmd_bitsel u_bitsel (
        .bit_addr  (req.addr[7:0]),
        .byte_addr (bs_byte),
        .bit_pos   (bs_pos),
        .to_sfr    (bs_sfr)
    );

    // Decodes an operation and its effective address onto a target.
    function automatic mmd_tgt_type decode(input mmd_op_type  op,
                                           input logic [15:0] a,
                                           input logic        fwe,
                                           input logic        bsfr);
        mmd_tgt_type t;
        t = T_IRAM;
        unique case (op)
            OP_CODE_RD:  t = (a <= `MMD_FLASH_TOP) ? T_FLASH : T_NONE;
            OP_XDATA_RD: t = T_XRAM;
            OP_XDATA_WR: begin
                if (fwe) begin
                    t = (a <= `MMD_FLASH_TOP) ? T_FLASH : T_NONE;
                end else begin
                    t = T_XRAM;
                end
            end
            OP_DIR_RD, OP_DIR_WR: begin
                if (a[`MMD_DIR_SFR_BIT]) begin
                    if (a[7:0] == `MMD_SFR_SP) begin
                        t = T_SP;
                    end else if (a[7:0] == `MMD_SFR_PAGE) begin
                        t = T_PAGE;
                    end else begin
                        t = T_SFR;
                    end
                end
            end
            OP_BIT_RD, OP_BIT_WR: t = bsfr ? T_SFR : T_IRAM;
            OP_IND_RD, OP_IND_WR, OP_PUSH, OP_POP: t = T_IRAM;
        endcase
        return t;
    endfunction

    // Sequencer: accept, fetch pointer, access, answer, write back.
    always_comb begin
        mmd_op_type  lop;
        mmd_tgt_type lt;
        logic [15:0] la;
        logic        launch;
        logic [7:0]  src;
        logic [7:0]  merged;
        lop        = req_ff.op;
        lt         = T_NONE;
        la         = 16'h0000;
        launch     = 1'b0;
        src        = `MMD_BYTE_ZERO;
        merged     = `MMD_BYTE_ZERO;
        nxt_state  = state_ff;
        nxt_req    = req_ff;
        nxt_tgt    = tgt_ff;
        nxt_rsp    = rsp_ff;
        nxt_addr   = addr_ff;
        nxt_bitpos = bitpos_ff;
        nxt_sp     = sp_ff;
        nxt_page   = page_ff;
        nxt_rspv   = 1'b0;
        nxt_flash  = flash_ff;
        nxt_sfr    = sfr_ff;
        nxt_flash.rd = 1'b0;
        nxt_flash.wr = 1'b0;
        nxt_sfr.rd   = 1'b0;
        nxt_sfr.wr   = 1'b0;
        iram_we    = 1'b0;
        iram_addr  = addr_ff[7:0];
        iram_wdata = req_ff.wdata;
        xram_we    = 1'b0;
        xram_addr  = addr_ff[8:0];
        xram_wdata = req_ff.wdata;
        unique case (state_ff)
            S_IDLE: begin
                if (accept) begin
                    nxt_req = req;
                    lop     = req.op;
                    unique case (req.op)
                        OP_PUSH: begin
                            la     = {8'h00, 8'(sp_ff + `MMD_INC)};
                            nxt_sp = 8'(sp_ff + `MMD_INC);
                            launch = 1'b1;
                        end
                        OP_POP: begin
                            la     = {8'h00, sp_ff};
                            nxt_sp = 8'(sp_ff - `MMD_INC);
                            launch = 1'b1;
                        end
                        OP_BIT_RD, OP_BIT_WR: begin
                            la         = {8'h00, bs_byte};
                            nxt_bitpos = bs_pos;
                            launch     = 1'b1;
                        end
                        OP_IND_RD, OP_IND_WR: begin
                            iram_addr = {3'h0, bank, 2'h0, req.ptr_sel};
                            nxt_state = S_PTR;
                        end
                        default: begin
                            if (req.via_ri && (req.op == OP_XDATA_RD ||
                                               req.op == OP_XDATA_WR)) begin
                                iram_addr = {3'h0, bank, 2'h0, req.ptr_sel};
                                nxt_state = S_PTR;
                            end else begin
                                la     = req.addr;
                                launch = 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_PTR: begin
                // Pointer byte now sits on the internal RAM read data.
                if (lop == OP_XDATA_RD || lop == OP_XDATA_WR) begin
                    la = {page_ff, iram_rdata};
                end else begin
                    la = {8'h00, iram_rdata};
                end
                launch = 1'b1;
            end
            S_ACC: begin
                iram_we = (tgt_ff == T_IRAM) && (lop == OP_DIR_WR ||
                          lop == OP_IND_WR || lop == OP_PUSH);
                xram_we = (tgt_ff == T_XRAM) && (lop == OP_XDATA_WR);
                if (lop == OP_DIR_WR && tgt_ff == T_SP) begin
                    nxt_sp = req_ff.wdata;
                end
                if (lop == OP_DIR_WR && tgt_ff == T_PAGE) begin
                    nxt_page = {`MMD_HIGH_ZERO, req_ff.wdata[0]};
                end
                nxt_state = S_DONE;
            end
            S_DONE: begin
                unique case (tgt_ff)
                    T_IRAM:  src = iram_rdata;
                    T_XRAM:  src = xram_rdata;
                    T_FLASH: src = flash_rdata;
                    T_SFR:   src = sfr_rdata;
                    T_SP:    src = sp_ff;
                    T_PAGE:  src = page_ff;
                    T_NONE:  src = `MMD_BYTE_ZERO;
                endcase
                merged = src;
                merged[bitpos_ff] = req_ff.wbit;
                nxt_rsp.bitval    = src[bitpos_ff];
                nxt_rsp.reserved  = (tgt_ff == T_NONE) &&
                    (lop == OP_CODE_RD || lop == OP_XDATA_WR);
                nxt_rsp.lock_byte = (tgt_ff == T_FLASH) &&
                    (addr_ff == `MMD_FLASH_TOP);
                if (lop == OP_BIT_WR) begin
                    // Bit writes are read, merge, write so neighbours stay.
                    nxt_rsp.data = merged;
                    nxt_sfr.wr    = (tgt_ff == T_SFR);
                    nxt_sfr.wdata = merged;
                    nxt_state     = S_WB;
                end else begin
                    nxt_rsp.data = src;
                    nxt_rspv     = 1'b1;
                    nxt_state    = S_IDLE;
                end
            end
            S_WB: begin
                iram_we    = (tgt_ff == T_IRAM);
                iram_wdata = rsp_ff.data;
                nxt_rspv   = 1'b1;
                nxt_state  = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
        if (launch) begin
            lt              = decode(lop, la, flash_wr_enable, bs_sfr);
            nxt_tgt         = lt;
            nxt_addr        = la;
            nxt_flash.addr  = la;
            nxt_flash.wdata = (state_ff == S_IDLE) ? req.wdata : req_ff.wdata;
            nxt_flash.rd    = (lt == T_FLASH) && (lop == OP_CODE_RD);
            nxt_flash.wr    = (lt == T_FLASH) && (lop == OP_XDATA_WR);
            nxt_sfr.addr    = {8'h00, la[7:0]};
            nxt_sfr.wdata   = nxt_flash.wdata;
            nxt_sfr.rd      = (lt == T_SFR) && (lop != OP_DIR_WR);
            nxt_sfr.wr      = (lt == T_SFR) && (lop == OP_DIR_WR);
            nxt_state       = S_ACC;
        end
        nxt_ready = (nxt_state == S_IDLE);
    end

    // Registers; a low clock enable freezes every one of them.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff  <= S_IDLE;
            req_ff    <= '0;
            tgt_ff    <= T_NONE;
            rsp_ff    <= '0;
            flash_ff  <= '0;
            sfr_ff    <= '0;
            addr_ff   <= 16'h0000;
            bitpos_ff <= 3'h0;
            sp_ff     <= `MMD_SP_RESET;
            page_ff   <= `MMD_PAGE_RESET;
            ready_ff  <= 1'b0;
            rspv_ff   <= 1'b0;
        end else if (ce) begin
            state_ff  <= nxt_state;
            req_ff    <= nxt_req;
            tgt_ff    <= nxt_tgt;
            rsp_ff    <= nxt_rsp;
            flash_ff  <= nxt_flash;
            sfr_ff    <= nxt_sfr;
            addr_ff   <= nxt_addr;
            bitpos_ff <= nxt_bitpos;
            sp_ff     <= nxt_sp;
            page_ff   <= nxt_page;
            ready_ff  <= nxt_ready;
            rspv_ff   <= nxt_rspv;
        end
    end

    // Outputs come straight from the registers above.
    assign req_ready          = ready_ff;
    assign rsp_valid          = rspv_ff;
    assign rsp                = rsp_ff;
    assign flash_port         = flash_ff;
    assign sfr_port           = sfr_ff;
    assign stack_pointer      = sp_ff;
    assign xram_page_register = page_ff;

    // Checks on the decoding, kept beside the logic they watch.
    a_flash_range: assert property (@(posedge mclk) disable iff (rst)
        (flash_ff.rd || flash_ff.wr) |-> flash_ff.addr <= `MMD_FLASH_TOP)
        else $error("flash strobe outside program range");
    a_code_reserved: assert property (@(posedge mclk) disable iff (rst)
        (ce && accept && req.op == OP_CODE_RD && req.addr > `MMD_FLASH_TOP)
        |=> !flash_ff.rd ##2 (!ce || (rsp_ff.reserved || !rspv_ff)))
        else $error("reserved code address reached flash");
    a_flash_write: assert property (@(posedge mclk) disable iff (rst)
        (ce && accept && req.op == OP_XDATA_WR && !req.via_ri)
        |=> flash_ff.wr == ($past(flash_wr_enable)
                            && $past(req.addr) <= `MMD_FLASH_TOP))
        else $error("flash write strobe does not follow enable");
    a_dir_sfr: assert property (@(posedge mclk) disable iff (rst)
        (ce && accept && req.op == OP_DIR_RD && req.addr[7]
         && req.addr[7:0] != `MMD_SFR_SP && req.addr[7:0] != `MMD_SFR_PAGE)
        |=> sfr_ff.rd && sfr_ff.addr[7:0] == $past(req.addr[7:0]))
        else $error("direct upper access missed register space");
    a_ind_ptr: assert property (@(posedge mclk) disable iff (rst)
        (accept && (req.op == OP_IND_RD || req.op == OP_IND_WR))
        |-> iram_addr == {3'h0, program_status_word[4:3], 2'h0, req.ptr_sel})
        else $error("indirect pointer not taken from active bank");
    a_bit_map: assert property (@(posedge mclk) disable iff (rst)
        (ce && accept && req.op == OP_BIT_RD && !req.addr[7])
        |=> addr_ff[7:0] == 8'h20 + {4'h0, $past(req.addr[6:3])}
            && bitpos_ff == $past(req.addr[2:0]))
        else $error("bit address mapped to wrong byte");
    a_push_step: assert property (@(posedge mclk) disable iff (rst)
        (ce && accept && req.op == OP_PUSH)
        |=> sp_ff == 8'($past(sp_ff) + 8'h01) && addr_ff[7:0] == sp_ff)
        else $error("push did not step stack pointer");
    a_sp_reset: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> sp_ff == 8'h07)
        else $error("stack pointer not 0x07 after reset");
    a_page_high: assert property (@(posedge mclk) disable iff (rst)
        page_ff[7:1] == 7'h00)
        else $error("page register upper bits not zero");
    a_xram_page: assert property (@(posedge mclk) disable iff (rst)
        (ce && state_ff == S_PTR && req_ff.op == OP_XDATA_RD)
        |=> addr_ff == {page_ff, $past(iram_rdata)})
        else $error("register indirect external address lacks page");
endmodule

// ===== tb/mmd_far_model.sv
/* Far-side model: flash array and outer register space of the decoder.
   Assumes rd and wr strobes last one cycle and data is read a cycle on. */
`timescale 1ns/100ps

module mmd_far_model
    import mmd_pkg::*;
(
    // Clock and strobes.
    input  wire logic        mclk,
    input  wire mmd_ext_type flash_port,
    input  wire mmd_ext_type sfr_port,
    // Read data.
    output logic      [7:0]  flash_rdata,
    output logic      [7:0]  sfr_rdata
);
    logic [7:0] sfr_mem [256];

    // Registers start from a known pattern so reads can be predicted.
    initial begin
        for (int i = 0; i < 256; i++) sfr_mem[i] = 8'(i) ^ 8'h5a;
    end

    // Data is valid only in the cycle after a read; otherwise it toggles,
    // so a sample taken a cycle late cannot pass by luck.
    always @(posedge mclk) begin
        flash_rdata <= flash_port.rd ? flash_port.addr[15:8] ^
            flash_port.addr[7:0] ^ 8'h3c : ~flash_rdata;
        sfr_rdata <= sfr_port.rd ? sfr_mem[sfr_port.addr[7:0]] : ~sfr_rdata;
        if (sfr_port.wr) sfr_mem[sfr_port.addr[7:0]] <= sfr_port.wdata;
    end
endmodule

// ===== tb/mmd_decoder_bench.sv
/* Bench of the memory map decoder: drives core requests and compares
   every read answer with a reference model kept in arrays.
   Assumes the far-side model serves flash and register reads. */
`timescale 1ns/100ps

module mmd_decoder_bench;
    import mmd_pkg::*;
    // Design signals.
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        req_valid = 1'b0;
    logic        fwe = 1'b0;
    logic [7:0]  status_word = 8'h00;
    mmd_req_type req = '0;
    logic        req_ready, rsp_valid;
    mmd_rsp_type rsp;
    mmd_ext_type flash_port, sfr_port;
    logic [7:0]  flash_rdata, sfr_rdata, stack_pointer, pg_reg;
    // Reference model and bookkeeping.
    logic [7:0]  iram [256];
    logic [7:0]  xram [512];
    logic [7:0]  sfr_m [256];
    logic [7:0]  sp = 8'h07;
    logic        pg = 1'b0;
    logic [1:0]  bank = 2'b00;
    logic        fmode = 1'b0;
    logic [15:0] lfsr = 16'd41392;
    logic [15:0] code_addr [6] = '{16'h0000, 16'h1234, 16'h3dfe,
                                   16'h3dff, 16'h3e00, 16'hffff};
    int          fl_wr = 0;
    int          mismatches = 0;
    int          total_checks = 0;

    // Design and its far side.
    mmd_decoder i_dut (
        .mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .program_status_word(status_word), .flash_wr_enable(fwe),
        .flash_port(flash_port), .flash_rdata(flash_rdata),
        .sfr_port(sfr_port), .sfr_rdata(sfr_rdata),
        .stack_pointer(stack_pointer), .xram_page_register(pg_reg));
    mmd_far_model i_far (
        .mclk(mclk), .flash_port(flash_port), .sfr_port(sfr_port),
        .flash_rdata(flash_rdata), .sfr_rdata(sfr_rdata));

    // Free-running clock and a count of flash write strobes.
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        if (flash_port.wr) fl_wr++;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], ^(lfsr & 16'hb400)};
        return lfsr[7:0];
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One request, held until taken; a read answer is checked against the
    // model. The idle cycle before it may drop the clock enable.
    task automatic run(input mmd_op_type op, input logic [15:0] a,
                       input logic [7:0] wd = 8'h00, input logic wb = 1'b0,
                       input logic ps = 1'b0, input logic ri = 1'b0);
        logic [7:0] p, e, cv, bb, by;
        logic [8:0] xa;
        logic [1:0] lf;
        int         n;
        int         f0;
        p = iram[{3'b000, bank, 2'b00, ps}];
        xa = ri ? {pg, p} : a[8:0];
        bb = a[7] ? {a[7:3], 3'b000} : {4'h2, a[6:3]};
        by = a[7] ? sfr_m[bb] : iram[bb];
        lf = {a > 16'h3dff, a == 16'h3dff};
        cv = lf[1] ? 8'h00 : a[15:8] ^ a[7:0] ^ 8'h3c;
        e = a[7] ? sfr_m[a[7:0]] : iram[a[7:0]];
        if (a[7:0] == 8'h81) e = sp;
        if (a[7:0] == 8'haa) e = {7'h00, pg};
        f0 = fl_wr;
        n = 0;
        @(posedge mclk);
        #1 ce = lfsr[2];
        @(posedge mclk);
        #1 ce = 1'b1;
        status_word = {3'b000, bank, 3'b000};
        fwe = fmode;
        req = '{op, a, wd, wb, ps, ri};
        req_valid = 1'b1;
        do @(negedge mclk); while (!req_ready && ++n < 40);
        @(posedge mclk);
        #1 req_valid = 1'b0;
        do @(negedge mclk); while (!rsp_valid && ++n < 40);
        if (!rsp_valid) chk(16'h0000, 16'h0001);
        case (op)
            OP_DIR_RD: chk(rsp.data, e);
            OP_DIR_WR: begin
                if (a[7:0] == 8'h81) sp = wd;
                else if (a[7:0] == 8'haa) pg = wd[0];
                else if (a[7]) sfr_m[a[7:0]] = wd;
                else iram[a[7:0]] = wd;
            end
            OP_IND_RD: chk(rsp.data, iram[p]);
            OP_IND_WR: iram[p] = wd;
            OP_PUSH: begin
                sp = sp + 8'h01;
                iram[sp] = wd;
            end
            OP_POP: begin
                chk(rsp.data, iram[sp]);
                sp = sp - 8'h01;
            end
            OP_BIT_RD: chk(rsp.bitval, by[a[2:0]]);
            OP_BIT_WR: begin
                by[a[2:0]] = wb;
                if (a[7]) sfr_m[bb] = by;
                else iram[bb] = by;
                chk(rsp.data, by);
            end
            OP_CODE_RD: begin
                chk({rsp.reserved, rsp.lock_byte}, lf);
                chk(rsp.data, cv);
            end
            OP_XDATA_RD: chk(rsp.data, xram[xa]);
            OP_XDATA_WR: begin
                if (!fmode) xram[xa] = wd;
                else chk(16'(fl_wr - f0), 16'(a <= 16'h3dff));
            end
            default: ;
        endcase
        chk(stack_pointer, sp);
        chk(pg_reg, {7'h00, pg});
    endtask

    // Main sequence: reset, then every access kind with awkward cases.
    initial begin
        foreach (sfr_m[i]) sfr_m[i] = 8'(i) ^ 8'h5a;
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        chk(stack_pointer, 8'h07);
        chk(pg_reg, 8'h00);
        run(OP_PUSH, 16'h0000, rnd());
        run(OP_DIR_RD, 16'h0008);
        run(OP_POP, 16'h0000);
        for (int b = 0; b < 4; b++) begin
            bank = 2'(b);
            run(OP_DIR_WR, 16'haa, rnd() & 8'hfe | 8'(b));
            run(OP_DIR_RD, 16'haa);
            run(OP_DIR_WR, 16'(8 * b + 1), 8'(8'h80 + 4 * b));
            run(OP_DIR_WR, 16'(8 * b), 8'(8'h40 + b));
            run(OP_IND_WR, 16'h0, rnd(), 1'b0, 1'b1);
            run(OP_IND_WR, 16'h0, rnd());
            run(OP_DIR_RD, 16'(8'h80 + 4 * b));
            run(OP_IND_RD, 16'h0, 8'h00, 1'b0, 1'b1);
            run(OP_DIR_RD, 16'(8'h40 + b));
            run(OP_XDATA_WR, 16'h0, rnd(), 1'b0, 1'b0, 1'b1);
            run(OP_XDATA_RD, 16'h0, 8'h00, 1'b0, 1'b0, 1'b1);
            run(OP_XDATA_RD, {lfsr[15:9], pg, 8'(8'h40 + b)});
        end
        run(OP_XDATA_WR, 16'h01ff, rnd());
        fmode = 1'b1;
        run(OP_XDATA_WR, 16'h3dff, rnd());
        run(OP_XDATA_WR, 16'h3e00, rnd());
        run(OP_XDATA_RD, 16'h3dff);
        fmode = 1'b0;
        foreach (code_addr[i]) run(OP_CODE_RD, code_addr[i]);
        for (int i = 0; i < 16; i++) run(OP_DIR_WR, 16'(8'h20 + i), rnd());
        // Bit operations on both halves; the upper half merges over the
        // register port, so a stale byte there would show as a mismatch.
        for (int i = 0; i < 24; i++) begin
            void'(rnd());
            run(OP_BIT_WR, {9'h000, lfsr[6:0]}, 8'h00,
                lfsr[9]);
            run(OP_BIT_RD, {9'h000, lfsr[8:2]});
            run(OP_DIR_RD, {12'h002, lfsr[6:3]});
            run(OP_BIT_WR, {9'h001, lfsr[12:6]}, 8'h00,
                lfsr[9]);
            run(OP_BIT_RD, {9'h001, lfsr[14:8]});
        end
        run(OP_DIR_WR, 16'h0081, 8'hfe);
        repeat (3) run(OP_PUSH, 16'h0, rnd());
        repeat (3) run(OP_POP, 16'h0);
        report_and_stop();
    end

    // Watchdog, far beyond the roughly 1100 cycles the sequence needs.
    initial begin
        #(6000 * 50);
        mismatches++;
        report_and_stop();
    end
endmodule
